// *** hdl/sma_defines.svh ***
// Purpose: shared constants of the sequenced math accelerator
// Assumes: byte-wide register bus, one clock at 20 MHz
// Notes:   offsets are byte addresses on the register bus
`ifndef SMA_DEFINES_SVH
`define SMA_DEFINES_SVH

// register addresses
`define SMA_ADDR_SHIFT_CTL  8'hD1
`define SMA_ADDR_CTL_STAT   8'hD2
`define SMA_ADDR_OPA        8'hD3
`define SMA_ADDR_OPB        8'hD4
`define SMA_ADDR_ACC        8'hD5
// host-side registers of its own
`define SMA_ADDR_HOST_LAST  8'hF0
`define SMA_ADDR_HOST_STAT  8'hF1

// accel_control_status fields
`define SMA_BIT_BUSY        7
`define SMA_BIT_OVF         6
`define SMA_BIT_SCB         5
`define SMA_BIT_CLEAR       4
// shift_control fields
`define SMA_BIT_LEFT        7
`define SMA_BIT_CIRC        6
`define SMA_BIT_SCE         5
`define SMA_SHIFT_CTL_RST   8'h00

// timing: oscillator periods and machine cycles
`define SMA_CLK_NS          50
`define SMA_MC_TCLCL        4
`define SMA_DIV32_TCLCL     36
`define SMA_DIV16_TCLCL     24
`define SMA_NORM_TCLCL      36
`define SMA_DIV_DONE_MC     9
`define SMA_MUL_DONE_MC     6
// datapath step counts, one step per clock
`define SMA_DIV32_STEPS     6'h20
`define SMA_DIV16_STEPS     6'h10
`define SMA_MUL_STEPS       6'h10
`define SMA_NORM_MAX        6'h1F

`endif

// *** hdl/sma_pkg.sv ***
// Purpose: types of the sequenced math accelerator
// Assumes: constants come from sma_defines.svh
// Notes:   state and operation codes are written out in binary
package sma_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        SMA_IDLE   = 3'b000,
        SMA_LOAD_A = 3'b001,
        SMA_DIV_B  = 3'b010,
        SMA_LOAD_B = 3'b011,
        SMA_MUL_A  = 3'b100,
        SMA_RUN    = 3'b101,
        SMA_FIN    = 3'b110,
        SMA_ERR    = 3'b111
    } sma_state_type;

    // operation inferred from access order
    typedef enum logic [2:0] {
        SMA_OP_DIV32 = 3'b000,
        SMA_OP_DIV16 = 3'b001,
        SMA_OP_MUL   = 3'b010,
        SMA_OP_SHIFT = 3'b011,
        SMA_OP_NORM  = 3'b100
    } sma_op_type;

endpackage

// *** hdl/sma_if.sv ***
// Purpose: register bus between processor side and accelerator
// Assumes: one cycle strobes, read data one cycle after read strobe
// Notes:   no clocking block; both ends share the system clock
`timescale 1ns/1ps
interface sma_if;
    logic [7:0] addr;   // register address
    logic [7:0] wdata;  // write data
    logic       wr;     // write strobe
    logic       rd;     // read strobe
    logic [7:0] rdata;  // read data, cycle after rd

    modport dev  (input addr, input wdata, input wr, input rd,
                  output rdata);
    modport host (output addr, output wdata, output wr, output rd,
                  input rdata);
endinterface

// *** hdl/sma_accel.sv ***
// Purpose: math accelerator: divide, multiply, shift, normalize
// Assumes: one clock per oscillator period, four per machine cycle
// Notes:   bit-serial datapath, one step per clock
// How it works
// - operation chosen by order of port accesses
// - 16/16 divide done within 24 clocks
// - 32/16 divide done within 36 clocks
// - normalize within 36 clocks, 5-bit count
// - clear bit empties A, B and accumulator
// - carry bit feeds shifts when enabled
// - overflow on divide by zero or over FFFFh
// - busy flag set during operation, then cleared
// - shift count field sets shift distance
// - carry enters shift path only when enabled
// - circular mode wraps bits end to end
// - direction bit picks left or right
// - zero shift count means normalize
// - out-of-order access corrupts until busy cleared
// - registers other than A, B and accumulator may interleave with operand accesses
// - divide loads A then B, reads back MSB first
// - divide busy clears within 9 machine cycles
// - multiply loads B then A, product read from A
// - multiply busy clears within 6 machine cycles
// - shift loads A, then writes shift control
// - normalize shifts out leading zeros, counts shifts
// - multiply and divide results add into accumulator
// - accumulator port five bytes, only when idle
`timescale 1ns/1ps
`include "sma_defines.svh"
module sma_accel (
    input  wire logic clk,
    input  wire logic sys_rst,
    sma_if.dev        bus,
    output logic      busy,
    output logic      overflow
);
    sma_pkg::sma_state_type state_q, state_d;   // sequencer state
    sma_pkg::sma_op_type    op_q, op_d;         // inferred operation
    logic [31:0] a_q, a_d;          // operand A / result
    logic [15:0] b_q, b_d;          // operand B / remainder
    logic [15:0] dvs_q, dvs_d;      // divisor held during divide
    logic [39:0] acc_q, acc_d;      // accumulator
    logic [2:0]  cnt_q, cnt_d;      // bytes loaded in this phase
    logic [5:0]  step_q, step_d;    // datapath step counter
    logic [7:0]  shCtl_q, shCtl_d;  // shift_control register
    logic        scb_q, scb_d;      // shift_carry_bit
    logic        mof_q, mof_d;      // overflow_flag
    logic        mst_q, mst_d;      // busy_flag
    logic [1:0]  rdA_q, rdA_d;      // A read pointer, MSB first
    logic        rdB_q, rdB_d;      // B read pointer, MSB first
    logic [2:0]  rdC_q, rdC_d;      // accumulator read pointer
    logic [2:0]  wrC_q, wrC_d;      // accumulator write pointer
    logic [7:0]  rdData_q, rdData_d; // registered read data

    // access decode
    logic wrA, wrB, wrC, wrSh, wrCtl, anyAcc;
    assign wrA    = bus.wr && (bus.addr == `SMA_ADDR_OPA);
    assign wrB    = bus.wr && (bus.addr == `SMA_ADDR_OPB);
    assign wrC    = bus.wr && (bus.addr == `SMA_ADDR_ACC);
    assign wrSh   = bus.wr && (bus.addr == `SMA_ADDR_SHIFT_CTL);
    assign wrCtl  = bus.wr && (bus.addr == `SMA_ADDR_CTL_STAT);
    // any touch of an operand or accumulator port
    assign anyAcc = (bus.wr || bus.rd) &&
                    ((bus.addr == `SMA_ADDR_OPA) ||
                     (bus.addr == `SMA_ADDR_OPB) ||
                     (bus.addr == `SMA_ADDR_ACC));

    // datapath step helpers
    logic        outBit, inBit;     // shift bit leaving / entering
    logic [31:0] shifted;           // A after one shift step
    logic [16:0] trial, diff;       // divide partial remainder
    logic [16:0] sum;               // multiply partial sum
    logic [4:0]  shCount;
    assign shCount = shCtl_q[4:0];

    // one shift step: direction, carry and wrap selection
    always_comb begin
        outBit  = shCtl_q[`SMA_BIT_LEFT] ? a_q[31] : a_q[0];
        if (shCtl_q[`SMA_BIT_SCE]) begin
            inBit = scb_q;
        end else if (shCtl_q[`SMA_BIT_CIRC]) begin
            inBit = outBit;
        end else begin
            inBit = 1'b0;
        end
        shifted = shCtl_q[`SMA_BIT_LEFT] ? {a_q[30:0], inBit}
                                         : {inBit, a_q[31:1]};
        // restoring divide: shift remainder, try subtract
        trial   = {b_q, a_q[31]};
        diff    = trial - {1'b0, dvs_q};
        // shift-add multiply: add multiplicand when low bit set
        sum     = {1'b0, a_q[31:16]} + {1'b0, (a_q[0] ? b_q : 16'h0000)};
    end

    // next-state and register update logic
    always_comb begin
        state_d  = state_q;
        op_d     = op_q;
        a_d      = a_q;
        b_d      = b_q;
        dvs_d    = dvs_q;
        acc_d    = acc_q;
        cnt_d    = cnt_q;
        step_d   = step_q;
        shCtl_d  = shCtl_q;
        scb_d    = scb_q;
        mof_d    = mof_q;
        mst_d    = mst_q;
        rdA_d    = rdA_q;
        rdB_d    = rdB_q;
        rdC_d    = rdC_q;
        wrC_d    = wrC_q;
        rdData_d = rdData_q;

        // read mux; pointers advance on each read
        if (bus.rd) begin
            if (bus.addr == `SMA_ADDR_CTL_STAT) begin
                rdData_d = {mst_q, mof_q, scb_q, 5'h00};
            end else if (bus.addr == `SMA_ADDR_SHIFT_CTL) begin
                rdData_d = shCtl_q;
            end else if (bus.addr == `SMA_ADDR_OPA) begin
                rdData_d = a_q[{rdA_q, 3'b000} +: 8];
                rdA_d    = rdA_q - 2'h1;
            end else if (bus.addr == `SMA_ADDR_OPB) begin
                rdData_d = rdB_q ? b_q[15:8] : b_q[7:0];
                rdB_d    = ~rdB_q;
            end else if (bus.addr == `SMA_ADDR_ACC) begin
                rdData_d = acc_q[{rdC_q, 3'b000} +: 8];
                rdC_d    = (rdC_q == 3'h0) ? 3'h4 : rdC_q - 3'h1;
            end else begin
                rdData_d = 8'h00;   // unmapped reads as zero
            end
        end

        // control/status write: carry bit, overflow clear, clear ops
        if (wrCtl) begin
            scb_d = bus.wdata[`SMA_BIT_SCB];
            mof_d = bus.wdata[`SMA_BIT_OVF];
            if (bus.wdata[`SMA_BIT_CLEAR]) begin
                a_d   = 32'h0000_0000;
                b_d   = 16'h0000;
                acc_d = 40'h00_0000_0000;
                wrC_d = 3'h0;
            end
        end
        // shift control is frozen while the datapath uses it
        if (wrSh && (state_q != sma_pkg::SMA_RUN)) begin
            shCtl_d = bus.wdata;
        end

        // sequencer: the access order selects the operation
        case (state_q)
            sma_pkg::SMA_IDLE: begin
                if (wrA) begin
                    a_d     = {24'h00_0000, bus.wdata};
                    cnt_d   = 3'h1;
                    mst_d   = 1'b1;
                    state_d = sma_pkg::SMA_LOAD_A;
                end else if (wrB) begin
                    b_d     = {8'h00, bus.wdata};
                    mst_d   = 1'b1;
                    state_d = sma_pkg::SMA_LOAD_B;
                end else if (wrC) begin
                    acc_d[{wrC_q, 3'b000} +: 8] = bus.wdata;
                    wrC_d = (wrC_q == 3'h4) ? 3'h0 : wrC_q + 3'h1;
                end
            end
            sma_pkg::SMA_LOAD_A: begin
                if (wrA && (cnt_q != 3'h4)) begin
                    a_d[{cnt_q[1:0], 3'b000} +: 8] = bus.wdata;
                    cnt_d = cnt_q + 3'h1;
                end else if (wrB && (cnt_q == 3'h2 || cnt_q == 3'h4)) begin
                    b_d     = {8'h00, bus.wdata};
                    op_d    = (cnt_q == 3'h4) ? sma_pkg::SMA_OP_DIV32
                                              : sma_pkg::SMA_OP_DIV16;
                    state_d = sma_pkg::SMA_DIV_B;
                end else if (wrSh && (cnt_q == 3'h4)) begin
                    op_d    = (bus.wdata[4:0] == 5'h00)
                              ? sma_pkg::SMA_OP_NORM
                              : sma_pkg::SMA_OP_SHIFT;
                    step_d  = 6'h00;
                    state_d = sma_pkg::SMA_RUN;
                end else if (anyAcc) begin
                    state_d = sma_pkg::SMA_ERR;
                end
            end
            sma_pkg::SMA_DIV_B: begin
                if (wrB) begin
                    // divisor saved, remainder starts at zero
                    dvs_d  = {bus.wdata, b_q[7:0]};
                    b_d    = 16'h0000;
                    if (op_q == sma_pkg::SMA_OP_DIV16) begin
                        a_d = {a_q[15:0], 16'h0000};
                    end
                    step_d  = 6'h00;
                    state_d = sma_pkg::SMA_RUN;
                end else if (anyAcc) begin
                    state_d = sma_pkg::SMA_ERR;
                end
            end
            sma_pkg::SMA_LOAD_B: begin
                if (wrB) begin
                    b_d[15:8] = bus.wdata;
                    cnt_d     = 3'h0;
                    state_d   = sma_pkg::SMA_MUL_A;
                end else if (anyAcc) begin
                    state_d = sma_pkg::SMA_ERR;
                end
            end
            sma_pkg::SMA_MUL_A: begin
                if (wrA && (cnt_q == 3'h0)) begin
                    a_d   = {24'h00_0000, bus.wdata};
                    cnt_d = 3'h1;
                end else if (wrA) begin
                    // multiplier to A low half, multiplicand to B
                    a_d     = {16'h0000, b_q};
                    b_d     = {bus.wdata, a_q[7:0]};
                    op_d    = sma_pkg::SMA_OP_MUL;
                    step_d  = 6'h00;
                    state_d = sma_pkg::SMA_RUN;
                end else if (anyAcc) begin
                    state_d = sma_pkg::SMA_ERR;
                end
            end
            sma_pkg::SMA_RUN: begin
                step_d = step_q + 6'h01;
                if (anyAcc) begin
                    state_d = sma_pkg::SMA_ERR;
                end else begin
                    case (op_q)
                        sma_pkg::SMA_OP_DIV32,
                        sma_pkg::SMA_OP_DIV16: begin
                            if (!diff[16]) begin
                                b_d = diff[15:0];
                                a_d = {a_q[30:0], 1'b1};
                            end else begin
                                b_d = trial[15:0];
                                a_d = {a_q[30:0], 1'b0};
                            end
                            if (step_q == ((op_q == sma_pkg::SMA_OP_DIV32)
                                ? `SMA_DIV32_STEPS : `SMA_DIV16_STEPS)
                                - 6'h01) begin
                                state_d = sma_pkg::SMA_FIN;
                            end
                        end
                        sma_pkg::SMA_OP_MUL: begin
                            a_d = {sum, a_q[15:1]};
                            if (step_q == `SMA_MUL_STEPS - 6'h01) begin
                                state_d = sma_pkg::SMA_FIN;
                            end
                        end
                        sma_pkg::SMA_OP_SHIFT: begin
                            a_d = shifted;
                            if (shCtl_q[`SMA_BIT_SCE]) begin
                                scb_d = outBit;
                            end
                            if (step_q[4:0] == shCount - 5'h01) begin
                                state_d = sma_pkg::SMA_FIN;
                            end
                        end
                        default: begin
                            // normalize: left until MSB set
                            if (a_q[31] || step_q == `SMA_NORM_MAX) begin
                                state_d = sma_pkg::SMA_FIN;
                            end else begin
                                a_d          = {a_q[30:0], 1'b0};
                                shCtl_d[4:0] = step_q[4:0] + 5'h01;
                            end
                        end
                    endcase
                end
            end
            sma_pkg::SMA_FIN: begin
                mst_d   = 1'b0;
                rdA_d   = 2'h3;
                rdB_d   = 1'b1;
                rdC_d   = 3'h4;
                state_d = sma_pkg::SMA_IDLE;
                if (op_q == sma_pkg::SMA_OP_MUL ||
                    op_q == sma_pkg::SMA_OP_DIV32 ||
                    op_q == sma_pkg::SMA_OP_DIV16) begin
                    acc_d = acc_q + {8'h00, a_q};
                    if (a_q[31:16] != 16'h0000) begin
                        mof_d = 1'b1;
                    end
                    if (op_q != sma_pkg::SMA_OP_MUL && dvs_q == 16'h0000)
                    begin
                        mof_d = 1'b1;
                    end
                end
            end
            default: begin
                // corrupted: hold busy until software clears it
                mst_d = 1'b1;
            end
        endcase

        // software clearing busy aborts and restarts the sequencer
        if (wrCtl && !bus.wdata[`SMA_BIT_BUSY] &&
            state_q != sma_pkg::SMA_FIN) begin
            mst_d   = 1'b0;
            state_d = sma_pkg::SMA_IDLE;
            rdA_d   = 2'h3;
            rdB_d   = 1'b1;
            rdC_d   = 3'h4;
            wrC_d   = 3'h0;
        end
    end

    // register all state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q  <= sma_pkg::SMA_IDLE;
            op_q     <= sma_pkg::SMA_OP_DIV32;
            a_q      <= 32'h0000_0000;
            b_q      <= 16'h0000;
            dvs_q    <= 16'h0000;
            acc_q    <= 40'h00_0000_0000;
            cnt_q    <= 3'h0;
            step_q   <= 6'h00;
            shCtl_q  <= `SMA_SHIFT_CTL_RST;
            scb_q    <= 1'b0;
            mof_q    <= 1'b0;
            mst_q    <= 1'b0;
            rdA_q    <= 2'h3;
            rdB_q    <= 1'b1;
            rdC_q    <= 3'h4;
            wrC_q    <= 3'h0;
            rdData_q <= 8'h00;
        end else begin
            state_q  <= state_d;
            op_q     <= op_d;
            a_q      <= a_d;
            b_q      <= b_d;
            dvs_q    <= dvs_d;
            acc_q    <= acc_d;
            cnt_q    <= cnt_d;
            step_q   <= step_d;
            shCtl_q  <= shCtl_d;
            scb_q    <= scb_d;
            mof_q    <= mof_d;
            mst_q    <= mst_d;
            rdA_q    <= rdA_d;
            rdB_q    <= rdB_d;
            rdC_q    <= rdC_d;
            wrC_q    <= wrC_d;
            rdData_q <= rdData_d;
        end
    end

    // outputs straight from flops
    assign bus.rdata = rdData_q;
    assign busy      = mst_q;
    assign overflow  = mof_q;
endmodule

// *** hdl/sma_host.sv ***
// Purpose: processor-side end: relays software accesses to the bus
// Assumes: software issues operand accesses in the documented order
// Notes:   link reads complete later; result kept in a host register
`timescale 1ns/1ps
`include "sma_defines.svh"
module sma_host (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    sma_if.host             bus,
    input  wire logic [7:0] usrAddr,
    input  wire logic [7:0] usrWdata,
    input  wire logic       usrWr,
    input  wire logic       usrRd,
    output logic      [7:0] usrRdata
);
    logic [7:0] addr_q, addr_d;     // link address
    logic [7:0] wdata_q, wdata_d;   // link write data
    logic       wr_q, wr_d;         // link write strobe
    logic       rd_q, rd_d;         // link read strobe
    logic       pend_q, pend_d;     // link read data due this cycle
    logic [7:0] last_q, last_d;     // last link read result
    logic [7:0] urd_q, urd_d;       // user read data

    logic hostReg;                  // access hits a host register
    assign hostReg = (usrAddr == `SMA_ADDR_HOST_LAST) ||
                     (usrAddr == `SMA_ADDR_HOST_STAT);

    // relay in issue order; no reordering keeps the sequence intact
    always_comb begin
        addr_d  = addr_q;
        wdata_d = wdata_q;
        wr_d    = 1'b0;
        rd_d    = 1'b0;
        pend_d  = rd_q;
        last_d  = pend_q ? bus.rdata : last_q;
        urd_d   = urd_q;
        if (usrWr && !hostReg) begin
            addr_d  = usrAddr;
            wdata_d = usrWdata;
            wr_d    = 1'b1;
        end else if (usrRd && !hostReg) begin
            addr_d  = usrAddr;
            rd_d    = 1'b1;
        end
        // host registers answer at once, others return zero
        if (usrRd) begin
            if (usrAddr == `SMA_ADDR_HOST_LAST) begin
                urd_d = last_q;
            end else if (usrAddr == `SMA_ADDR_HOST_STAT) begin
                urd_d = {7'h00, (rd_q | pend_q)};
            end else begin
                urd_d = 8'h00;
            end
        end
    end

    // register the link and user outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_q  <= 8'h00;
            wdata_q <= 8'h00;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            pend_q  <= 1'b0;
            last_q  <= 8'h00;
            urd_q   <= 8'h00;
        end else begin
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            pend_q  <= pend_d;
            last_q  <= last_d;
            urd_q   <= urd_d;
        end
    end

    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr    = wr_q;
    assign bus.rd    = rd_q;
    assign usrRdata  = urd_q;
endmodule

// *** verif/sma_monitor.sv ***
// Purpose: bus-side checks of the accelerator across the shared bus
// Assumes: host relays each user strobe outside its own registers to the bus one cycle later
// Notes:   bounds are in clocks, four clocks to a machine cycle
`timescale 1ns/1ps
`include "sma_defines.svh"
module sma_monitor (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       busy,
    input wire logic       overflow
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // plain booleans so that mulLoad, div16Load and divTail never meet a logical and
    logic wrA;    // write to operand A
    logic wrB;    // write to operand B
    assign wrA = wr && addr == `SMA_ADDR_OPA;
    assign wrB = wr && addr == `SMA_ADDR_OPB;
    // a fresh load starts only from an idle sequencer
    sequence mulLoad;
        !busy ##1 wrB ##1 wrB ##1 wrA ##1 wrA;
    endsequence
    sequence div16Load;
        !busy ##1 wrA ##1 wrA ##1 wrB ##1 wrB;
    endsequence
    // last dividend byte then both divisor bytes: only a divide does this
    sequence divTail;
        wrA ##1 wrB ##1 wrB;
    endsequence
    sequence zeroDivisor;
        wrA ##1 wrB && wdata == 8'h00 ##1 wrB && wdata == 8'h00;
    endsequence
    chk_busy_from_write: assert property (
        $rose(busy) |-> $past(wr)) else $error("busy rose without write");
    chk_div_done: assert property (
        divTail |-> ##[1:36] !busy) else $error("divide busy too long");
    chk_div16_done: assert property (
        div16Load |-> ##[1:24] !busy) else $error("short divide too long");
    chk_mul_done: assert property (
        mulLoad |-> ##[1:24] !busy) else $error("multiply busy too long");
    chk_shift_done: assert property (
        wr && addr == `SMA_ADDR_SHIFT_CTL && busy |-> ##[1:36] !busy)
        else $error("shift or normalize busy too long");
    chk_abort_clear: assert property (
        wr && addr == `SMA_ADDR_CTL_STAT && !wdata[7] && busy |=> !busy)
        else $error("busy not cleared by software");
    chk_divzero_flag: assert property (
        zeroDivisor |-> ##[1:36] overflow) else $error("no divide by zero flag");
    chk_acc_idle: assert property (
        wr && addr == `SMA_ADDR_ACC && !busy |=> !busy)
        else $error("accumulator write started an operation");
endmodule

// *** verif/tb_top.sv ***
// Purpose: drives the host user port and checks results end to end
// Assumes: relayed reads land in the host last-read register
// Notes:   every operation idles 30 or 40 cycles, 4 to 6 past its bound
`timescale 1ns/1ps
`include "sma_defines.svh"
module tb_top;
    localparam logic [7:0] OPA = `SMA_ADDR_OPA;
    localparam logic [7:0] OPB = `SMA_ADDR_OPB;
    localparam logic [7:0] ACC = `SMA_ADDR_ACC;
    localparam logic [7:0] CTL = `SMA_ADDR_CTL_STAT;
    localparam logic [7:0] SHC = `SMA_ADDR_SHIFT_CTL;
    logic       clk = 1'b0;       // system clock
    logic       sysRst = 1'b1;    // synchronous reset
    logic [7:0] usrAddr = 8'h00;  // user port address
    logic [7:0] usrWdata = 8'h00; // user port write data
    logic       usrWr = 1'b0;     // user write strobe
    logic       usrRd = 1'b0;     // user read strobe
    logic [7:0] usrRdata;         // user read data
    logic       busy;             // accelerator busy level
    logic       overflow;         // accelerator overflow level
    int         numErrors = 0;
    int         samplesChecked = 0;
    int         cycles = 0;
    always #25 clk = ~clk;
    sma_if bus ();
    sma_host i_sma_host (.clk(clk), .sys_rst(sysRst), .bus(bus),
        .usrAddr(usrAddr), .usrWdata(usrWdata), .usrWr(usrWr),
        .usrRd(usrRd), .usrRdata(usrRdata));
    sma_accel i_sma_accel (.clk(clk), .sys_rst(sysRst), .bus(bus),
        .busy(busy), .overflow(overflow));
    sma_monitor i_sma_monitor (.clk(clk), .sys_rst(sysRst),
        .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
        .rdata(bus.rdata), .busy(busy), .overflow(overflow));
    task automatic stopTest;
        $display("checks %0d mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus cycle; every input set once per edge, so no double drive
    task automatic step(logic w, logic r, logic [7:0] a, logic [7:0] d);
        usrWr <= w;
        usrRd <= r;
        usrAddr <= a;
        usrWdata <= d;
        @(posedge clk);
    endtask
    task automatic idle(int n);
        repeat (n) step(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    // n bytes, lowest first, with no gap so load orders stay intact
    task automatic wq(logic [7:0] a, logic [39:0] v, int n);
        for (int i = 0; i < n; i++) step(1'b1, 1'b0, a, v[8*i+:8]);
    endtask
    // relayed read, then fetch the stored byte from the last-read register
    task automatic rd1(logic [7:0] a, logic [7:0] exp);
        step(1'b0, 1'b1, a, 8'h00);
        idle(3);
        step(1'b0, 1'b1, `SMA_ADDR_HOST_LAST, 8'h00);
        idle(1);
        check(usrRdata, exp);
    endtask
    // n bytes, highest first
    task automatic rq(logic [7:0] a, logic [39:0] v, int n);
        for (int i = 0; i < n; i++) rd1(a, v[8*(n-1-i)+:8]);
    endtask
    always @(posedge clk) begin
        cycles++;
        // generous ceiling: the sequence needs under six hundred cycles
        if (cycles == 4000) begin
            numErrors++;
            stopTest;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        sysRst <= 1'b0;
        wq(OPA, 40'h0000123456, 4);
        wq(OPB, 40'h0000000010, 2);
        idle(40);
        rd1(CTL, 8'h40);
        rq(OPA, 40'h0000012345, 4);
        rq(OPB, 40'h0000000006, 2);
        $display("test divide done");
        wq(CTL, 40'h0000000010, 1);
        wq(OPB, 40'h0000000003, 2);
        wq(OPA, 40'h0000001234, 2);
        idle(30);
        rq(OPA, 40'h000000369C, 4);
        rd1(CTL, 8'h00);
        rq(ACC, 40'h000000369C, 5);
        wq(ACC, 40'h0504030201, 5);
        rq(ACC, 40'h0504030201, 5);
        $display("test multiply done");
        wq(OPA, 40'h0000000005, 2);
        wq(OPB, 40'h0000000000, 2);
        idle(30);
        rd1(CTL, 8'h40);
        wq(CTL, 40'h0000000000, 1);
        wq(OPA, 40'h0080000001, 4);
        rd1(CTL, 8'h80);
        wq(SHC, 40'h00000000C4, 1);
        idle(40);
        rq(OPA, 40'h0000000018, 4);
        wq(CTL, 40'h0000000020, 1);
        wq(OPA, 40'h0000000002, 4);
        wq(SHC, 40'h0000000021, 1);
        idle(40);
        rq(OPA, 40'h0080000001, 4);
        wq(OPA, 40'h0000001000, 4);
        wq(SHC, 40'h0000000000, 1);
        idle(40);
        rq(OPA, 40'h0080000000, 4);
        rd1(SHC, 8'h13);
        wq(OPA, 40'h0000000000, 4);
        wq(SHC, 40'h0000000000, 1);
        idle(40);
        rd1(CTL, 8'h00);
        rd1(SHC, 8'h1F);
        $display("test shift done");
        wq(OPA, 40'h0000000001, 1);
        step(1'b0, 1'b1, OPB, 8'h00);
        idle(3);
        rd1(CTL, 8'h80);
        wq(CTL, 40'h0000000000, 1);
        idle(2);
        rd1(CTL, 8'h00);
        idle(1);
        $display("test abort done");
        stopTest;
    end
endmodule
